//--- logic/mcct_timer.sv
// three-channel 16-bit capture/compare timer with register port
//
// Overview of operation
// - count and capture registers take whole words only
// - other registers accept byte and word access
// - run bit starts counting, clearing stops it
// - free-running wrap sets overflow flag
// - overflow flag with enable raises interrupt
// - compare-match clear source gives periodic counting
// - match/capture flag with enable raises interrupt
// - compare match drives pin 0, 1 or toggle
// - equal level leaves pin unchanged
// - selected pin edge captures counter value
// - capture event may clear the counter
// - each register independently capture or compare
// - write to sync counter presets all sync counters
// - sync clear follows another sync channel's clear
// - channels 0 to 2 all support sync
// - buffered compare reloads from paired buffer
// - buffered capture moves old value to buffer
// - PWM mode follows compare levels, full duty range
// - phase counting on channels 1 and 2
// - C buffers A, D buffers B
// - reset sets counters 0000, capture/compare registers FFFF
// - flag clears by write 0 after read 1
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "mcct_map.svh"
module mcct_timer import mcct_pkg::*; (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire mcct_bus_type      busReq,
    output logic [15:0]            busRdata,
    input  wire logic [2:0][3:0]   ioIn,
    output logic [2:0][3:0]        ioOut,
    output logic [2:0][3:0]        ioOe,
    input  wire logic [3:0]        extClkIn,
    output logic [2:0]             irqReq
);
    mcct_state_type st_ff;
    mcct_state_type nxt_st;
    logic [2:0]      tick;
    logic [2:0]      upDir;
    logic [2:0]      ownClr;
    logic [2:0]      clrNow;
    logic [2:0]      ovfEv;
    logic [2:0]      unfEv;
    logic [2:0][3:0] capEv;
    logic [2:0][3:0] cmpEv;
    logic            syncClr;
    logic [1:0]      bCh;
    logic [3:0]      bOff;
    logic            bGlb;
    logic            bChOk;
    logic            bWord;

    // io nibble of register r (A in the top nibble)
    function automatic logic [3:0] nib(input logic [15:0] cfg, input int r);
        return cfg[15-4*r -: 4];
    endfunction : nib

    // bus address decode
    assign bCh   = busReq.addr[5:4];
    assign bOff  = {busReq.addr[3:1], 1'b0};
    assign bGlb  = {busReq.addr[7:1], 1'b0} == `MCCT_ADDR_GLB;
    assign bChOk = busReq.addr[7:6] == 2'h0 && bCh != 2'h3;
    assign bWord = busReq.byteEn == 2'h3;

    // count ticks, events and clears
    always_comb begin
        logic [3:0] n;
        logic [2:0] src;
        logic a;
        logic b;
        logic ap;
        logic bp;
        logic rise;
        logic fall;
        n = '0;
        src = '0;
        a = 1'b0;
        b = 1'b0;
        ap = 1'b0;
        bp = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        tick = '0;
        upDir = '1;
        ownClr = '0;
        capEv = '0;
        cmpEv = '0;
        for (int c = 0; c < 3; c++) begin
            rise = st_ff.clkS2[c] & ~st_ff.clkS3[c];
            fall = ~st_ff.clkS2[c] & st_ff.clkS3[c];
            case (st_ff.ctl[c][`MCCT_CKS_LSB +: 2])
                2'h0: tick[c] = st_ff.run[c];
                2'h1: tick[c] = st_ff.run[c] & rise;
                2'h2: tick[c] = st_ff.run[c] & fall;
                default: tick[c] = st_ff.run[c] & (rise | fall);
            endcase
            if (c > 0 && st_ff.mode[c][1:0] == `MCCT_MD_PHASE) begin
                // quadrature decode, A leading B counts up
                a = st_ff.clkS2[2*c-2];
                b = st_ff.clkS2[2*c-1];
                ap = st_ff.clkS3[2*c-2];
                bp = st_ff.clkS3[2*c-1];
                tick[c] = st_ff.run[c] & ((a ^ ap) ^ (b ^ bp));
                upDir[c] = a ^ bp;
            end
            for (int r = 0; r < 4; r++) begin
                n = nib(st_ff.ioCfg[c], r);
                rise = st_ff.pinS2[c][r] & ~st_ff.pinS3[c][r];
                fall = ~st_ff.pinS2[c][r] & st_ff.pinS3[c][r];
                // C and D exist on channel 0 only, and act as buffers when paired
                if (r < 2 || (c == 0 && !st_ff.mode[0][r])) begin
                    if (n[`MCCT_IO_CAP]) begin
                        capEv[c][r] = n[1] ? (rise | fall) : (n[0] ? fall : rise);
                    end else begin
                        cmpEv[c][r] = tick[c] && st_ff.cnt[c] == st_ff.cc[c][r];
                    end
                end
            end
            src = st_ff.ctl[c][`MCCT_CLR_LSB +: 3];
            if (src[0] ^ src[1]) begin
                ownClr[c] = capEv[c][{src[2], src[1]}] | cmpEv[c][{src[2], src[1]}];
            end
        end
        syncClr = |(ownClr & st_ff.sync);
        for (int c = 0; c < 3; c++) begin
            clrNow[c] = ownClr[c] | (st_ff.sync[c] & syncClr &
                        st_ff.ctl[c][`MCCT_CLR_LSB +: 3] == `MCCT_CLR_SYNC);
            ovfEv[c] = tick[c] & upDir[c] & ~clrNow[c] & (st_ff.cnt[c] == `MCCT_CNT_MAX);
            unfEv[c] = tick[c] & ~upDir[c] & ~clrNow[c] & (st_ff.cnt[c] == `MCCT_CNT_RST);
        end
    end

    // next state: events first, then bus writes that override them
    always_comb begin
        logic [3:0] n;
        logic [7:0] clrF;
        logic [7:0] setF;
        n = '0;
        clrF = '0;
        setF = '0;
        nxt_st = st_ff;
        nxt_st.pinS1 = ioIn;
        nxt_st.pinS2 = st_ff.pinS1;
        nxt_st.pinS3 = st_ff.pinS2;
        nxt_st.clkS1 = extClkIn;
        nxt_st.clkS2 = st_ff.clkS1;
        nxt_st.clkS3 = st_ff.clkS2;
        nxt_st.rdata = '0;
        for (int c = 0; c < 3; c++) begin
            if (clrNow[c]) begin
                nxt_st.cnt[c] = `MCCT_CNT_RST;
            end else if (tick[c]) begin
                nxt_st.cnt[c] = upDir[c] ? st_ff.cnt[c] + 16'h0001 : st_ff.cnt[c] - 16'h0001;
            end
            for (int r = 0; r < 4; r++) begin
                n = nib(st_ff.ioCfg[c], r);
                if (capEv[c][r]) begin
                    if (c == 0 && r < 2 && st_ff.mode[0][r | 2]) begin
                        nxt_st.cc[0][r | 2] = st_ff.cc[0][r];
                    end
                    nxt_st.cc[c][r] = st_ff.cnt[c];
                end
                if (cmpEv[c][r]) begin
                    if (c == 0 && r < 2 && st_ff.mode[0][r | 2]) begin
                        nxt_st.cc[0][r] = st_ff.cc[0][r | 2];
                    end
                    case (n[1:0])
                        2'h1: nxt_st.pinLvl[c][r] = 1'b0;
                        2'h2: nxt_st.pinLvl[c][r] = 1'b1;
                        2'h3: nxt_st.pinLvl[c][r] = ~st_ff.pinLvl[c][r];
                        default: nxt_st.pinLvl[c][r] = st_ff.pinLvl[c][r];
                    endcase
                end
                // pwm period restart returns compare pins to their initial level
                if (st_ff.mode[c][1:0] == `MCCT_MD_PWM && clrNow[c] && !n[`MCCT_IO_CAP]) begin
                    nxt_st.pinLvl[c][r] = n[`MCCT_IO_INIT];
                end
            end
            // flags: write-0-after-read-1 clear, set wins
            clrF = '0;
            if (busReq.wrStb && bChOk && !bGlb && bCh == c[1:0] && bOff == `MCCT_OFF_IRQ && busReq.byteEn[0]) begin
                clrF = st_ff.armed[c] & ~busReq.wdata[7:0] & `MCCT_FLG_CLRM;
            end
            setF = {2'h0, unfEv[c], ovfEv[c], capEv[c] | cmpEv[c]};
            nxt_st.flag[c] = (st_ff.flag[c] & ~clrF) | setF;
            nxt_st.armed[c] = st_ff.armed[c] & ~clrF;
            nxt_st.flag[c][`MCCT_FLG_DIR] = tick[c] ? ~upDir[c] : st_ff.flag[c][`MCCT_FLG_DIR];
        end
        // register writes
        if (busReq.wrStb && bGlb) begin
            if (busReq.byteEn[1]) begin
                nxt_st.run = busReq.wdata[10:8];
            end
            if (busReq.byteEn[0]) begin
                nxt_st.sync = busReq.wdata[2:0];
            end
        end else if (busReq.wrStb && bChOk) begin
            case (bOff)
                `MCCT_OFF_CTL: begin
                    if (busReq.byteEn[1]) nxt_st.ctl[bCh] = busReq.wdata[15:8];
                    if (busReq.byteEn[0]) nxt_st.mode[bCh] = busReq.wdata[7:0];
                end
                `MCCT_OFF_IO: begin
                    if (busReq.byteEn[1]) nxt_st.ioCfg[bCh][15:8] = busReq.wdata[15:8];
                    if (busReq.byteEn[0]) nxt_st.ioCfg[bCh][7:0] = busReq.wdata[7:0];
                    // stopped channel: pins take the new initial level
                    if (!st_ff.run[bCh]) begin
                        for (int r = 0; r < 4; r++) begin
                            n = nib(nxt_st.ioCfg[bCh], r);
                            if (!n[`MCCT_IO_CAP]) nxt_st.pinLvl[bCh][r] = n[`MCCT_IO_INIT];
                        end
                    end
                end
                `MCCT_OFF_IRQ: begin
                    if (busReq.byteEn[1]) nxt_st.irqEn[bCh] = busReq.wdata[15:8];
                end
                `MCCT_OFF_CNT: begin
                    if (bWord) begin
                        for (int d = 0; d < 3; d++) begin
                            if (d == bCh || (st_ff.sync[bCh] && st_ff.sync[d])) begin
                                nxt_st.cnt[d] = busReq.wdata;
                            end
                        end
                    end
                end
                default: begin
                    if (bWord && (bCh == 2'h0 || !bOff[2])) begin
                        nxt_st.cc[bCh][bOff[2:1]] = busReq.wdata;
                    end
                end
            endcase
        end
        // register reads, data stand in the following cycle
        if (busReq.rdStb && bGlb) begin
            nxt_st.rdata = {5'h00, st_ff.run, 5'h00, st_ff.sync};
        end else if (busReq.rdStb && bChOk) begin
            case (bOff)
                `MCCT_OFF_CTL: nxt_st.rdata = {st_ff.ctl[bCh], st_ff.mode[bCh]};
                `MCCT_OFF_IO: nxt_st.rdata = st_ff.ioCfg[bCh];
                `MCCT_OFF_IRQ: begin
                    nxt_st.rdata = {st_ff.irqEn[bCh], st_ff.flag[bCh]};
                    if (busReq.byteEn[0]) begin
                        nxt_st.armed[bCh] = nxt_st.armed[bCh] | (st_ff.flag[bCh] & `MCCT_FLG_CLRM);
                    end
                end
                `MCCT_OFF_CNT: nxt_st.rdata = st_ff.cnt[bCh];
                default: nxt_st.rdata = (bCh == 2'h0 || !bOff[2]) ? st_ff.cc[bCh][bOff[2:1]] : 16'h0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.cc <= {12{`MCCT_CC_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs
    assign busRdata = st_ff.rdata;
    assign ioOut = st_ff.pinLvl;
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            irqReq[c] = |(st_ff.flag[c][5:0] & st_ff.irqEn[c][5:0]);
            for (int r = 0; r < 4; r++) begin
                ioOe[c][r] = (r < 2 || c == 0) && !st_ff.ioCfg[c][15-4*r-`MCCT_IO_CAP+3] &&
                             st_ff.ioCfg[c][12-4*r +: 2] != 2'h0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // any counter write on the bus, used to mask count checks
    logic wrCnt0;
    assign wrCnt0 = busReq.wrStb && bChOk && bOff == `MCCT_OFF_CNT;

    // counting, flags, pins and buffers
    stop_holds_a: assert property (!st_ff.run[0] && !wrCnt0 && !clrNow[0] |=> $stable(st_ff.cnt[0]))
        else $error("stopped counter moved");
    ovf_wrap_a: assert property (ovfEv[0] && !wrCnt0 |=> st_ff.flag[0][4] && st_ff.cnt[0] == 16'h0000)
        else $error("overflow wrap wrong");
    ovf_irq_a: assert property (st_ff.flag[0][4] && st_ff.irqEn[0][4] |-> irqReq[0])
        else $error("overflow irq missing");
    per_clear_a: assert property (cmpEv[1][0] && st_ff.ctl[1][2:0] == 3'h1 && !wrCnt0
        |=> st_ff.cnt[1] == 16'h0000 && st_ff.flag[1][0])
        else $error("periodic clear failed");
    match_irq_a: assert property (st_ff.flag[1][0] && st_ff.irqEn[1][0] |-> irqReq[1])
        else $error("match irq missing");
    set_level_a: assert property (cmpEv[1][0] && st_ff.ioCfg[1][13:12] == 2'h2 && !clrNow[1]
        |=> st_ff.pinLvl[1][0])
        else $error("set level not driven");
    toggle_lvl_a: assert property (cmpEv[1][0] && st_ff.ioCfg[1][13:12] == 2'h3 &&
        st_ff.mode[1][1:0] != `MCCT_MD_PWM |=> st_ff.pinLvl[1][0] != $past(st_ff.pinLvl[1][0]))
        else $error("toggle missing");
    cap_value_a: assert property (capEv[2][0] && !(busReq.wrStb && bChOk)
        |=> st_ff.cc[2][0] == $past(st_ff.cnt[2]))
        else $error("capture value wrong");
    sync_preset_a: assert property (wrCnt0 && bCh == 2'h1 && bWord && st_ff.sync[1] && st_ff.sync[2]
        |=> st_ff.cnt[2] == $past(busReq.wdata))
        else $error("sync preset missed");
    sync_clear_a: assert property (ownClr[0] && st_ff.sync[0] && st_ff.sync[1] &&
        st_ff.ctl[1][2:0] == 3'h3 && !busReq.wrStb |=> st_ff.cnt[1] == 16'h0000)
        else $error("sync clear missed");
    buf_reload_a: assert property (cmpEv[0][0] && st_ff.mode[0][2] && !busReq.wrStb
        |=> st_ff.cc[0][0] == $past(st_ff.cc[0][2]))
        else $error("buffer reload missed");
    set_wins_a: assert property (capEv[0][1] && busReq.wrStb && bChOk && bCh == 2'h0 &&
        bOff == `MCCT_OFF_IRQ |=> st_ff.flag[0][1])
        else $error("flag set lost");

    // stepping, quiet pins, capture buffering, flag retention, direction
    run_counts_a: assert property (st_ff.run[1] && st_ff.mode[1][1:0] == `MCCT_MD_NORM &&
        st_ff.ctl[1][4:3] == 2'h0 && !clrNow[1] && !wrCnt0
        |=> st_ff.cnt[1] == $past(st_ff.cnt[1]) + 16'h0001)
        else $error("running counter stalled");
    pin_quiet_a: assert property (!cmpEv[1][0] && !clrNow[1] && !(busReq.wrStb && bChOk)
        |=> $stable(st_ff.pinLvl[1][0]))
        else $error("pin moved without match");
    buf_capture_a: assert property (capEv[0][0] && st_ff.mode[0][2] && !(busReq.wrStb && bChOk)
        |=> st_ff.cc[0][2] == $past(st_ff.cc[0][0]))
        else $error("capture buffer not loaded");
    flag_keep_a: assert property (st_ff.flag[1][0] && !st_ff.armed[1][0] |=> st_ff.flag[1][0])
        else $error("flag cleared without read");
    phase_dir_a: assert property (tick[1] && st_ff.mode[1][1:0] == `MCCT_MD_PHASE
        |=> st_ff.flag[1][`MCCT_FLG_DIR] == ~$past(upDir[1]))
        else $error("direction flag wrong");

    // scenario covers
    cov_periodic: cover property (cmpEv[0][0] ##1 st_ff.cnt[0] == 16'h0000);
    cov_capture: cover property (capEv[1][0] && st_ff.mode[0][2]);
    cov_phase_down: cover property (tick[2] && !upDir[2]);
    cov_sync_clear: cover property (syncClr && st_ff.sync[1]);
    cov_toggle_out: cover property (cmpEv[1][0] && st_ff.ioCfg[1][13:12] == 2'h3);
endmodule : mcct_timer

//--- logic/mcct_map.svh
// register offsets, field positions, reset values and encodings of the timer
`ifndef MCCT_MAP_SVH
`define MCCT_MAP_SVH
// byte offsets inside one channel window (channel n at n*16)
`define MCCT_OFF_CTL  4'h0
`define MCCT_OFF_IO   4'h2
`define MCCT_OFF_IRQ  4'h4
`define MCCT_OFF_CNT  4'h6
`define MCCT_OFF_CCA  4'h8
`define MCCT_OFF_CCB  4'ha
`define MCCT_OFF_CCC  4'hc
`define MCCT_OFF_CCD  4'he
// shared run / sync word
`define MCCT_ADDR_GLB 8'h30
// reset values and counter maximum
`define MCCT_CNT_RST  16'h0000
`define MCCT_CC_RST   16'hffff
`define MCCT_CNT_MAX  16'hffff
// counter_control_reg fields
`define MCCT_CLR_LSB  0
`define MCCT_CKS_LSB  3
// clear_source_select codes
`define MCCT_CLR_NONE 3'h0
`define MCCT_CLR_SYNC 3'h3
// timer_mode_reg mode codes
`define MCCT_MD_NORM  2'h0
`define MCCT_MD_PWM   2'h1
`define MCCT_MD_PHASE 2'h2
// io nibble fields
`define MCCT_IO_CAP   3
`define MCCT_IO_INIT  2
// timer_flag_reg bit positions and clearable-flag mask
`define MCCT_FLG_OVF  4
`define MCCT_FLG_UNF  5
`define MCCT_FLG_DIR  6
`define MCCT_FLG_CLRM 8'h3f
`endif

//--- logic/mcct_pkg.sv
// types shared by the capture/compare timer
package mcct_pkg;
    // one register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic [1:0]  byteEn;
        logic        wrStb;
        logic        rdStb;
    } mcct_bus_type;

    // whole state of the timer
    typedef struct packed {
        logic [2:0]             run;
        logic [2:0]             sync;
        logic [2:0][7:0]        ctl;
        logic [2:0][7:0]        mode;
        logic [2:0][7:0]        irqEn;
        logic [2:0][7:0]        flag;
        logic [2:0][7:0]        armed;
        logic [2:0][15:0]       ioCfg;
        logic [2:0][15:0]       cnt;
        logic [2:0][3:0][15:0]  cc;
        logic [2:0][3:0]        pinLvl;
        logic [2:0][3:0]        pinS1;
        logic [2:0][3:0]        pinS2;
        logic [2:0][3:0]        pinS3;
        logic [3:0]             clkS1;
        logic [3:0]             clkS2;
        logic [3:0]             clkS3;
        logic [15:0]            rdata;
    } mcct_state_type;
endpackage : mcct_pkg

//--- test/mcct_host.sv
// bus master model driving the timer register port
`timescale 1ns/100ps
module mcct_host import mcct_pkg::*; (
    input  wire logic        clk_sys,
    output mcct_bus_type     busReq,
    input  wire logic [15:0] busRdata
);
    // idle bus from time zero
    initial begin
        busReq <= '0;
    end

    // one-cycle write strobe, then one idle edge so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
        busReq.addr   <= a;
        busReq.wdata  <= d;
        busReq.byteEn <= be;
        busReq.wrStb  <= 1'b1;
        @(posedge clk_sys);
        busReq.wrStb  <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    // one-cycle read strobe; data taken at the edge after the strobe
    task automatic rd(input logic [7:0] a, input logic [1:0] be, output logic [15:0] d);
        busReq.addr   <= a;
        busReq.byteEn <= be;
        busReq.rdStb  <= 1'b1;
        @(posedge clk_sys);
        busReq.rdStb  <= 1'b0;
        @(posedge clk_sys);
        d = busRdata;
    endtask : rd
endmodule : mcct_host

//--- test/tb.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/100ps
module tb import mcct_pkg::*;;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic [1:0]  be;
        logic        doWr;
        logic [15:0] exp;
    } mcct_row_type;

    logic             clk_sys;
    logic             rst_n;
    mcct_bus_type     busReq;
    logic [15:0]      busRdata;
    logic [2:0][3:0]  ioIn;
    logic [2:0][3:0]  ioOut;
    logic [2:0][3:0]  ioOe;
    logic [3:0]       extClkIn;
    logic [2:0]       irqReq;
    logic [15:0]      rd;
    logic [15:0]      rd2;
    int               errors;
    int               checks;
    int               cycles;
    int               n;
    // phase inputs {B, A}: four steps A leading, then four B leading
    logic [1:0]       ph [8] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0};

    // register accesses: address, data, lanes, write first, expected read
    mcct_row_type rows [9] = '{
        '{8'h06, 16'h0000, 2'h3, 1'b0, 16'h0000},
        '{8'h08, 16'h0000, 2'h3, 1'b0, 16'hffff},
        '{8'h0e, 16'h0000, 2'h3, 1'b0, 16'hffff},
        '{8'h08, 16'h1234, 2'h3, 1'b1, 16'h1234},
        '{8'h06, 16'h00aa, 2'h1, 1'b1, 16'h0000},
        '{8'h20, 16'h0300, 2'h2, 1'b1, 16'h0300},
        '{8'h20, 16'h0001, 2'h1, 1'b1, 16'h0301},
        '{8'h20, 16'h0000, 2'h3, 1'b1, 16'h0000},
        '{8'h32, 16'h0000, 2'h3, 1'b0, 16'h0000}
    };

    mcct_timer u_mcct_timer (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .busReq   (busReq),
        .busRdata (busRdata),
        .ioIn     (ioIn),
        .ioOut    (ioOut),
        .ioOe     (ioOe),
        .extClkIn (extClkIn),
        .irqReq   (irqReq)
    );

    mcct_host u_mcct_host (
        .clk_sys  (clk_sys),
        .busReq   (busReq),
        .busRdata (busRdata)
    );

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_of_test();
        end
    end

    // compare helpers
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chkBit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chkBit

    // edges until channel 1 pin A changes level
    task automatic waitFlip(output int cnt);
        logic lvl;
        lvl = ioOut[1][0];
        cnt = 0;
        do begin
            @(posedge clk_sys);
            cnt++;
        end while (ioOut[1][0] === lvl && cnt < 40);
    endtask : waitFlip

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // main sequence
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        ioIn = '0;
        extClkIn = '0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk16({13'h0, irqReq}, 16'h0000);
        foreach (rows[i]) begin
            if (rows[i].doWr)
                u_mcct_host.wr(rows[i].addr, rows[i].wdata, rows[i].be);
            u_mcct_host.rd(rows[i].addr, 2'h3, rd);
            chk16(rd, rows[i].exp);
        end
        // synchronous preset across all three channels
        u_mcct_host.wr(8'h30, 16'h0007, 2'h1);
        u_mcct_host.wr(8'h16, 16'h4321, 2'h3);
        u_mcct_host.rd(8'h06, 2'h3, rd);
        chk16(rd, 16'h4321);
        u_mcct_host.rd(8'h26, 2'h3, rd);
        chk16(rd, 16'h4321);
        u_mcct_host.wr(8'h30, 16'h0000, 2'h1);
        u_mcct_host.wr(8'h16, 16'h0000, 2'h3);
        u_mcct_host.rd(8'h06, 2'h3, rd);
        chk16(rd, 16'h4321);
        // capture on a rising pin edge while stopped
        u_mcct_host.wr(8'h26, 16'h0abc, 2'h3);
        u_mcct_host.wr(8'h22, 16'h8000, 2'h3);
        ioIn[2][0] <= 1'b1;
        repeat (8) @(posedge clk_sys);
        u_mcct_host.rd(8'h28, 2'h3, rd);
        chk16(rd, 16'h0abc);
        u_mcct_host.rd(8'h24, 2'h1, rd);
        chkBit(rd[0], 1'b1);
        // periodic count with toggle output, period cc+1
        u_mcct_host.wr(8'h10, 16'h0100, 2'h2);
        u_mcct_host.wr(8'h18, 16'h0005, 2'h3);
        u_mcct_host.wr(8'h12, 16'h3000, 2'h3);
        u_mcct_host.wr(8'h14, 16'h0100, 2'h2);
        u_mcct_host.wr(8'h30, 16'h0200, 2'h2);
        waitFlip(n);
        waitFlip(n);
        chk16(16'(n), 16'h0006);
        chkBit(ioOe[1][0], 1'b1);
        chkBit(ioOe[1][1], 1'b0);
        chkBit(ioOe[2][0], 1'b0);
        chkBit(irqReq[1], 1'b1);
        u_mcct_host.wr(8'h30, 16'h0000, 2'h2);
        // flag survives a zero write without a prior read
        u_mcct_host.wr(8'h14, 16'h0100, 2'h1);
        chkBit(irqReq[1], 1'b1);
        u_mcct_host.rd(8'h14, 2'h1, rd);
        u_mcct_host.wr(8'h14, 16'h0100, 2'h1);
        chkBit(irqReq[1], 1'b0);
        // free-running wrap on channel 0
        u_mcct_host.wr(8'h06, 16'hfffd, 2'h3);
        u_mcct_host.wr(8'h04, 16'h1000, 2'h2);
        u_mcct_host.wr(8'h30, 16'h0100, 2'h2);
        repeat (6) @(posedge clk_sys);
        u_mcct_host.wr(8'h30, 16'h0000, 2'h2);
        u_mcct_host.rd(8'h06, 2'h3, rd);
        chkBit(rd < 16'h0010, 1'b1);
        u_mcct_host.rd(8'h04, 2'h1, rd2);
        chkBit(rd2[4], 1'b1);
        chkBit(irqReq[0], 1'b1);
        // stopped counter holds
        repeat (4) @(posedge clk_sys);
        u_mcct_host.rd(8'h06, 2'h3, rd2);
        chk16(rd2, rd);
        // phase counting on channel 1, written while stopped
        u_mcct_host.wr(8'h16, 16'h0000, 2'h3);
        u_mcct_host.wr(8'h10, 16'h0002, 2'h1);
        u_mcct_host.wr(8'h30, 16'h0200, 2'h2);
        foreach (ph[i]) begin
            extClkIn[1:0] <= ph[i];
            repeat (4) @(posedge clk_sys);
            if (i % 4 == 3) begin
                u_mcct_host.rd(8'h16, 2'h3, rd);
                chk16(rd, (i == 3) ? 16'h0004 : 16'h0000);
            end
        end
        u_mcct_host.rd(8'h14, 2'h1, rd);
        chkBit(rd[6], 1'b1);
        u_mcct_host.wr(8'h30, 16'h0000, 2'h2);
        // reset after all channels are stopped restores counters and registers
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chkBit(irqReq[0], 1'b0);
        u_mcct_host.rd(8'h06, 2'h3, rd);
        chk16(rd, 16'h0000);
        u_mcct_host.rd(8'h18, 2'h3, rd);
        chk16(rd, 16'hffff);
        end_of_test();
    end
endmodule : tb
